//--- bpm_params.svh
// constants for the battery power manager
`ifndef BPM_PARAMS_SVH
`define BPM_PARAMS_SVH
`define BPM_CLK_HZ 40000000
`define BPM_SEC_CYCLES (`BPM_CLK_HZ)
`define BPM_HOLD_SEC 30
`define BPM_STEP_SEC 10
`define BPM_WARN_SEC 300
`define BPM_INST_STEP_DB 3
`define BPM_AVG_MAX_STEPS 18
`define BPM_INST_MAX_STEPS 2
`define BPM_POR_DELAY_RST 8'h02
`define BPM_ADDR_CTRL 12'h000
`define BPM_ADDR_DELAY 12'h004
`define BPM_ADDR_STATUS 12'h008
`define BPM_ADDR_GAIN 12'h00c
`endif

//--- bpm_pkg.sv
// types for the battery power manager
package bpm_pkg;
   typedef enum logic [1:0] {
      BPM_SCHEME_SHALLOW,
      BPM_SCHEME_DEEP,
      BPM_SCHEME_ADV,
      BPM_SCHEME_RSVD
   } bpm_scheme_e;
endpackage : bpm_pkg

//--- bpm_power_manager.sv
// low-supply power manager with apb registers
// Summary of operation
// (R01) three schemes select mute and recovery behaviour
// (R02) audio off, buttons ignored during power delay
// (R03) shallow: mute below 0.95, unmute above 1.1
// (R04) shallow: logic brownout resets, off until 1.1
// (R05) shallow: stayed above 0.6 resumes last memory
// (R06) shallow: fell below 0.6 restarts memory A
// (R07) deep: mute below 0.95 until 0.6 reset
// (R08) deep: after reset memory A, run above 1.1
// (R09) advanced: instant dip adds 3 dB cut
// (R10) 30 s hold-off after each instant cut
// (R11) second dip gives 6 dB, two steps max
// (R12) period above 1.1 clears instant cut
// (R13) two steps, period above 1.0 gives 3 dB
// (R14) average low: 1 dB per 10 s, mute at 18
// (R15) average high: unmute, restore 1 dB per 10 s
// (R16) no average action between 0.95 and 1.1
// (R17) instant and average cuts kept separately, summed
// (R18) advanced: shutdown reset, recover like shallow
// (R19) low-battery warning pulse on threshold crossing
// (R20) warning repeats every five minutes
// (R21) monitor supplies synchronous threshold flags
// (R22) timers run from a divided seconds tick
`timescale 1ns/1ps
`default_nettype none
`include "bpm_params.svh"
module bpm_power_manager
   import bpm_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `BPM_SEC_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [31:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic inst_below_095,
   input wire logic inst_below_100,
   input wire logic inst_above_110,
   input wire logic avg_below_095,
   input wire logic avg_above_110,
   input wire logic below_ramp_down,
   input wire logic below_060,
   input wire logic below_low_batt,
   input wire logic button_in,
   output logic audio_mute_q,
   output logic [4:0] gain_cut_db_q,
   output logic hw_reset_q,
   output logic restore_mem_a_q,
   output logic button_out_q,
   output logic low_batt_event_q
);
   // monitor flags are synchronous to clk, so they are used directly [R21]
   bpm_scheme_e scheme_q;
   logic [7:0] delay_sec_q;
   logic [7:0] delay_cnt_q;
   logic por_done_q;
   logic low_mute_q;
   logic in_reset_q;
   logic deep_fell_q;
   logic [1:0] inst_steps_q;
   logic [4:0] avg_steps_q;
   logic [4:0] hold_cnt_q;
   // low while the instant hold-off runs, high once monitoring periods run
   logic monitor_q;
   logic period_min110_q;
   logic period_min100_q;
   logic [3:0] step_cnt_q;
   logic [8:0] warn_cnt_q;
   logic warn_armed_q;
   logic sec_tick;

   bpm_sec_tick #(.CYCLES(SEC_CYCLES)) u_tick ( // [R22]
      .clk(clk),
      .srst(srst),
      .tick(sec_tick)
   );

   // apb decode; zero-wait slave, one-cycle access phase
   wire logic apb_access = psel && penable;
   wire logic apb_wr = apb_access && pwrite;
   wire logic [11:0] reg_addr = paddr[11:0];
   wire logic hit_ctrl = reg_addr == `BPM_ADDR_CTRL;
   wire logic hit_delay = reg_addr == `BPM_ADDR_DELAY;
   wire logic hit_status = reg_addr == `BPM_ADDR_STATUS;
   wire logic hit_gain = reg_addr == `BPM_ADDR_GAIN;
   wire logic hit_any = hit_ctrl || hit_delay || hit_status || hit_gain;
   wire logic [31:0] rd_mux =
      hit_ctrl ? {30'h0, scheme_q} :
      hit_delay ? {24'h0, delay_sec_q} :
      hit_status ? {26'h0, warn_armed_q, in_reset_q, low_mute_q, por_done_q,
                    inst_steps_q} :
      hit_gain ? {22'h0, avg_steps_q, gain_cut_db_q} : 32'h0;

   // derived supply conditions
   wire logic is_adv = scheme_q == BPM_SCHEME_ADV;
   wire logic is_deep = scheme_q == BPM_SCHEME_DEEP;
   wire logic reset_cond = is_deep ? below_060 : below_ramp_down; // [R04] [R07] [R18]
   // deep keeps waiting for 0.6 V before reset is allowed to end
   wire logic leave_reset = inst_above_110 && (!is_deep || deep_fell_q); // [R04] [R08]
   // the hold-off ignores dips; a monitoring period takes them unless two steps are already held
   wire logic hold_active = hold_cnt_q != 5'h0 && !monitor_q;
   wire logic inst_dip = is_adv && !in_reset_q && !avg_below_095 && inst_below_095 &&
                         !hold_active && inst_steps_q < `BPM_INST_MAX_STEPS; // [R09] [R11]
   wire logic period_end = sec_tick && hold_cnt_q == 5'h1;
   wire logic avg_step_now = sec_tick && step_cnt_q == 4'h1;
   wire logic avg_cut = is_adv && avg_below_095 &&
                        avg_steps_q < `BPM_AVG_MAX_STEPS; // [R14]
   wire logic avg_restore = is_adv && avg_above_110 && avg_steps_q != 5'h0; // [R15]
   wire logic [4:0] inst_db = 5'(inst_steps_q * `BPM_INST_STEP_DB);
   wire logic [4:0] total_cut = 5'(inst_db + avg_steps_q); // [R17]
   wire logic mute_now = !por_done_q || in_reset_q || low_mute_q ||
                         (is_adv && !avg_above_110 &&
                          avg_steps_q == `BPM_AVG_MAX_STEPS); // [R02] [R14] [R15]

   always_ff @(posedge clk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit_any;
         prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
      end
   end

   // settings; scheme steers all low-supply behaviour except the low-battery warning
   always_ff @(posedge clk) begin
      if (srst) begin
         scheme_q <= BPM_SCHEME_SHALLOW;
         delay_sec_q <= `BPM_POR_DELAY_RST;
      end else if (apb_wr && pstrb[0]) begin
         if (hit_ctrl && bpm_scheme_e'(pwdata[1:0]) != BPM_SCHEME_RSVD)
            scheme_q <= bpm_scheme_e'(pwdata[1:0]); // [R01]
         if (hit_delay)
            delay_sec_q <= pwdata[7:0];
      end
   end

   // power-on delay, restarted by each hardware reset
   always_ff @(posedge clk) begin
      if (srst || in_reset_q) begin
         delay_cnt_q <= 8'h0;
         por_done_q <= 1'b0;
      end else if (!por_done_q) begin
         if (delay_cnt_q >= delay_sec_q)
            por_done_q <= 1'b1; // [R02]
         else if (sec_tick)
            delay_cnt_q <= delay_cnt_q + 8'h1;
      end
   end

   // button gate: presses dropped until delay over; button_in is pre-synchronised
   always_ff @(posedge clk) begin
      if (srst)
         button_out_q <= 1'b0;
      else
         button_out_q <= button_in && por_done_q && !in_reset_q; // [R02]
   end

   // low-supply mute and hardware reset
   always_ff @(posedge clk) begin
      if (srst) begin
         low_mute_q <= 1'b0;
         in_reset_q <= 1'b0;
         deep_fell_q <= 1'b0;
         restore_mem_a_q <= 1'b1;
      end else if (in_reset_q) begin
         if (below_060) begin
            deep_fell_q <= 1'b1;
            restore_mem_a_q <= 1'b1; // [R06] [R08]
         end
         if (leave_reset && !below_060) begin
            in_reset_q <= 1'b0; // [R05] [R18]
            low_mute_q <= 1'b0;
            deep_fell_q <= 1'b0;
         end
      end else if (reset_cond) begin
         in_reset_q <= 1'b1; // [R04] [R07] [R18]
         restore_mem_a_q <= below_060; // [R05] [R06]
         deep_fell_q <= below_060;
      end else if (!is_adv) begin
         if (inst_below_095)
            low_mute_q <= 1'b1; // [R03] [R07]
         else if (inst_above_110 && !is_deep)
            low_mute_q <= 1'b0; // [R03]
      end else begin
         low_mute_q <= 1'b0;
         if (por_done_q)
            restore_mem_a_q <= 1'b0;
      end
   end

   // instant cuts: 30 s hold-off, then back-to-back 30 s monitoring periods
   always_ff @(posedge clk) begin
      if (srst || in_reset_q || !is_adv) begin
         inst_steps_q <= 2'h0;
         hold_cnt_q <= 5'h0;
         monitor_q <= 1'b0;
         period_min110_q <= 1'b1;
         period_min100_q <= 1'b1;
      end else if (inst_dip) begin
         inst_steps_q <= inst_steps_q + 2'h1; // [R09] [R11]
         hold_cnt_q <= 5'(`BPM_HOLD_SEC); // [R10]
         monitor_q <= 1'b0;
         period_min110_q <= 1'b1;
         period_min100_q <= 1'b1;
      end else if (inst_steps_q != 2'h0) begin
         if (period_end) begin
            // end of hold-off opens monitoring; end of a period judges its minimum
            if (monitor_q && period_min110_q && inst_above_110)
               inst_steps_q <= 2'h0; // [R12]
            else if (monitor_q && inst_steps_q == 2'h2 && period_min100_q && !inst_below_100)
               inst_steps_q <= 2'h1; // [R13]
            hold_cnt_q <= 5'(`BPM_HOLD_SEC);
            monitor_q <= 1'b1; // [R11]
            period_min110_q <= 1'b1;
            period_min100_q <= 1'b1;
         end else begin
            if (sec_tick)
               hold_cnt_q <= hold_cnt_q - 5'h1; // [R10]
            if (!inst_above_110)
               period_min110_q <= 1'b0;
            if (inst_below_100)
               period_min100_q <= 1'b0;
         end
      end
   end

   // average cuts every 10 s
   always_ff @(posedge clk) begin
      if (srst || in_reset_q || !is_adv) begin
         avg_steps_q <= 5'h0;
         step_cnt_q <= 4'(`BPM_STEP_SEC);
      end else if (!(avg_cut || avg_restore)) begin
         step_cnt_q <= 4'(`BPM_STEP_SEC); // [R16]
      end else if (avg_step_now) begin
         step_cnt_q <= 4'(`BPM_STEP_SEC);
         if (avg_cut)
            avg_steps_q <= avg_steps_q + 5'h1; // [R14]
         else
            avg_steps_q <= avg_steps_q - 5'h1; // [R15]
      end else if (sec_tick) begin
         step_cnt_q <= step_cnt_q - 4'h1;
      end
   end

   // outputs; average unmute comes at once when the average recovers, before any restore
   always_ff @(posedge clk) begin
      if (srst) begin
         audio_mute_q <= 1'b1;
         gain_cut_db_q <= 5'h0;
         hw_reset_q <= 1'b0;
      end else begin
         audio_mute_q <= mute_now; // [R02] [R15]
         gain_cut_db_q <= total_cut; // [R17]
         hw_reset_q <= in_reset_q; // [R04]
      end
   end

   // low-battery warning, repeated every five minutes
   always_ff @(posedge clk) begin
      if (srst || in_reset_q) begin
         warn_armed_q <= 1'b0;
         warn_cnt_q <= 9'h0;
         low_batt_event_q <= 1'b0;
      end else if (!warn_armed_q) begin
         low_batt_event_q <= below_low_batt && por_done_q; // [R19]
         warn_armed_q <= below_low_batt && por_done_q;
         warn_cnt_q <= 9'(`BPM_WARN_SEC);
      end else if (sec_tick && warn_cnt_q == 9'h1) begin
         low_batt_event_q <= 1'b1; // [R20]
         warn_cnt_q <= 9'(`BPM_WARN_SEC);
      end else begin
         low_batt_event_q <= 1'b0;
         if (sec_tick)
            warn_cnt_q <= warn_cnt_q - 9'h1;
      end
   end

   sequence s_dip_taken;
      inst_dip ##1 hold_active;
   endsequence

   a_dip_adds_step: assert property (@(posedge clk) disable iff (srst) // [R09]
      inst_dip |=> inst_steps_q == $past(inst_steps_q) + 2'h1)
      else $error("instant dip did not add a step");
   a_hold_blocks: assert property (@(posedge clk) disable iff (srst) // [R10]
      s_dip_taken |-> hold_cnt_q == 5'(`BPM_HOLD_SEC) && !inst_dip)
      else $error("dip taken during hold-off");
   a_inst_max: assert property (@(posedge clk) disable iff (srst) // [R11]
      inst_steps_q <= `BPM_INST_MAX_STEPS)
      else $error("more than two instant steps");
   a_avg_max: assert property (@(posedge clk) disable iff (srst) // [R14]
      avg_steps_q <= `BPM_AVG_MAX_STEPS)
      else $error("average steps above limit");
   a_mute_por: assert property (@(posedge clk) disable iff (srst) // [R02]
      !por_done_q |=> audio_mute_q && !button_out_q)
      else $error("audio or button live during delay");
   a_gain_sum: assert property (@(posedge clk) disable iff (srst) // [R17]
      ##1 gain_cut_db_q == $past(total_cut))
      else $error("gain cut is not sum of accumulators");
   a_avg_hold: assert property (@(posedge clk) disable iff (srst) // [R16]
      (is_adv && !avg_below_095 && !avg_above_110 && !in_reset_q) |=>
      avg_steps_q == $past(avg_steps_q))
      else $error("average cut changed in dead band");
   a_reset_out: assert property (@(posedge clk) disable iff (srst) // [R04]
      (!in_reset_q && reset_cond) |=> ##1 hw_reset_q)
      else $error("hardware reset not raised");
   a_warn_pulse: assert property (@(posedge clk) disable iff (srst) // [R19]
      low_batt_event_q |=> !low_batt_event_q)
      else $error("warning event longer than one cycle");
   a_deep_wait: assert property (@(posedge clk) disable iff (srst) // [R07]
      (is_deep && low_mute_q && !in_reset_q) |=> low_mute_q)
      else $error("deep scheme unmuted before reset");
   a_reset_mem: assert property (@(posedge clk) disable iff (srst) // [R06]
      (in_reset_q && below_060) |=> restore_mem_a_q)
      else $error("memory A not chosen after deep drop");
   a_reset_leave: assert property (@(posedge clk) disable iff (srst) // [R05]
      (in_reset_q && !is_deep && inst_above_110 && !below_060) |=> !in_reset_q)
      else $error("reset not left above turn-on level");
   a_avg_mute: assert property (@(posedge clk) disable iff (srst) // [R14]
      (is_adv && !avg_above_110 && avg_steps_q == `BPM_AVG_MAX_STEPS)
      |=> audio_mute_q)
      else $error("audio not muted at average cut limit");
   a_avg_unmute: assert property (@(posedge clk) disable iff (srst) // [R15]
      (is_adv && avg_above_110 && por_done_q && !in_reset_q && !low_mute_q)
      |=> !audio_mute_q)
      else $error("audio still muted with average recovered");
   a_period_clear: assert property (@(posedge clk) disable iff (srst) // [R12]
      (is_adv && !in_reset_q && !inst_dip && period_end && monitor_q &&
       period_min110_q && inst_above_110) |=> inst_steps_q == 2'h0)
      else $error("clean monitoring period kept an instant cut");
   a_period_halve: assert property (@(posedge clk) disable iff (srst) // [R13]
      (is_adv && !in_reset_q && period_end && monitor_q && inst_steps_q == 2'h2 &&
       !(period_min110_q && inst_above_110) && period_min100_q && !inst_below_100)
      |=> inst_steps_q == 2'h1)
      else $error("steady period did not drop to one step");
endmodule : bpm_power_manager
`default_nettype wire

//--- bpm_sec_tick.sv
// divider making a one-cycle pulse per second
`timescale 1ns/1ps
`default_nettype none
module bpm_sec_tick #(
   parameter int unsigned CYCLES = 40000000
) (
   input wire logic clk,
   input wire logic srst,
   output logic tick
);
   logic [31:0] cnt_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= 32'h0;
         tick <= 1'b0;
      end else if (cnt_q == CYCLES - 1) begin
         cnt_q <= 32'h0;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule : bpm_sec_tick
`default_nettype wire

//--- bpm_supply_model.sv
// supply monitor model: registered threshold flags from millivolt levels
`timescale 1ns/1ps
`default_nettype none
module bpm_supply_model #(
   parameter int RAMP_MV = 800,
   parameter int WARN_MV = 1080
) (
   input wire logic clk,
   input wire logic [15:0] v_i,
   input wire logic [15:0] v_a,
   output logic inst_below_095,
   output logic inst_below_100,
   output logic inst_above_110,
   output logic avg_below_095,
   output logic avg_above_110,
   output logic below_ramp_down,
   output logic below_060,
   output logic below_low_batt
);
   // flags change only at clk edges so the controller never sees a torn level
   always_ff @(posedge clk) begin
      inst_below_095 <= v_i < 950;
      inst_below_100 <= v_i < 1000;
      inst_above_110 <= v_i > 1100;
      avg_below_095 <= v_a < 950;
      avg_above_110 <= v_a > 1100;
      below_ramp_down <= v_i < RAMP_MV;
      below_060 <= v_i < 600;
      below_low_batt <= v_i < WARN_MV;
   end
endmodule : bpm_supply_model
`default_nettype wire

//--- testbench.sv
// self-checking bench for the battery power manager
`timescale 1ns/1ps
`default_nettype none
`include "bpm_params.svh"
module testbench;
   localparam int SC = 8;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic button_in = 1'b0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, audio_mute_q, hw_reset_q, restore_mem_a_q;
   logic button_out_q, low_batt_event_q;
   logic [4:0] gain_cut_db_q;
   logic [15:0] v_i = 16'd1200;
   logic [15:0] v_a = 16'd1200;
   logic inst_below_095, inst_below_100, inst_above_110, avg_below_095;
   logic avg_above_110, below_ramp_down, below_060, below_low_batt;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n_ev = 0;
   int e0;
   bpm_supply_model mon (
      .clk(clk),
      .v_i(v_i),
      .v_a(v_a),
      .inst_below_095(inst_below_095),
      .inst_below_100(inst_below_100),
      .inst_above_110(inst_above_110),
      .avg_below_095(avg_below_095),
      .avg_above_110(avg_above_110),
      .below_ramp_down(below_ramp_down),
      .below_060(below_060),
      .below_low_batt(below_low_batt)
   );
   bpm_power_manager #(.SEC_CYCLES(SC)) dut (
      .clk(clk),
      .srst(srst),
      .paddr(paddr),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .inst_below_095(inst_below_095),
      .inst_below_100(inst_below_100),
      .inst_above_110(inst_above_110),
      .avg_below_095(avg_below_095),
      .avg_above_110(avg_above_110),
      .below_ramp_down(below_ramp_down),
      .below_060(below_060),
      .below_low_batt(below_low_batt),
      .button_in(button_in),
      .audio_mute_q(audio_mute_q),
      .gain_cut_db_q(gain_cut_db_q),
      .hw_reset_q(hw_reset_q),
      .restore_mem_a_q(restore_mem_a_q),
      .button_out_q(button_out_q),
      .low_batt_event_q(low_batt_event_q)
   );
   always #12.5 clk = ~clk;
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (low_batt_event_q === 1'b1) n_ev <= n_ev + 1;
      // run should need about 8000 cycles
      if (cyc == 15000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic cy(input int n);
      repeat (n) @(posedge clk);
   endtask : cy
   task automatic sec(input int n);
      cy(n * SC);
   endtask : sec
   function automatic logic [15:0] rv(input int lo, input int hi);
      return 16'(lo + $urandom % (hi - lo + 1));
   endfunction : rv
   // total cut from instant steps and average steps, summed
   function automatic logic [4:0] exp_cut(input int inst, input int avg);
      return 5'(inst * `BPM_INST_STEP_DB + avg);
   endfunction : exp_cut
   // entered just after a rising edge; request held until pready
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic setv(input logic [15:0] i, input logic [15:0] a);
      v_i <= i;
      v_a <= a;
      cy(4);
   endtask : setv
   task automatic dip();
      setv(rv(810, 940), 16'd1200);
      setv(16'd1200, 16'd1200);
   endtask : dip
   initial begin
      rd = $urandom(88);
      cy(6);
      srst <= 1'b0;
      @(posedge clk);
      chk(audio_mute_q, 1);
      chk(restore_mem_a_q, 1);
      apb(1'b0, `BPM_ADDR_CTRL, 32'h0);
      chk(rd[1:0], 0);
      apb(1'b0, `BPM_ADDR_DELAY, 32'h0);
      chk(rd[7:0], `BPM_POR_DELAY_RST);
      apb(1'b0, 32'h10, 32'h0);
      chk(err, 1);
      button_in <= 1'b1;
      cy(3);
      chk(button_out_q, 0);
      sec(3);
      chk(button_out_q, 1);
      chk(audio_mute_q, 0);
      button_in <= 1'b0;
      e0 = n_ev;
      setv(16'd1050, 16'd1200);
      cy(2420);
      chk(n_ev - e0, 2);
      e0 = rv(0, 2);
      apb(1'b1, `BPM_ADDR_DELAY, e0);
      apb(1'b0, `BPM_ADDR_DELAY, 32'h0);
      chk(rd[7:0], e0);
      setv(rv(810, 940), 16'd1200);
      chk(audio_mute_q, 1);
      setv(rv(960, 1090), 16'd1200);
      chk(audio_mute_q, 1);
      setv(rv(1110, 1300), 16'd1200);
      chk(audio_mute_q, 0);
      setv(rv(610, 790), 16'd1200);
      chk(hw_reset_q, 1);
      setv(16'd1000, 16'd1200);
      chk(hw_reset_q, 1);
      setv(16'd1200, 16'd1200);
      chk(hw_reset_q, 0);
      chk(restore_mem_a_q, 0);
      sec(3);
      chk(audio_mute_q, 0);
      setv(rv(400, 590), 16'd1200);
      setv(16'd1200, 16'd1200);
      chk(restore_mem_a_q, 1);
      sec(3);
      apb(1'b1, `BPM_ADDR_CTRL, 32'h1);
      setv(16'd900, 16'd1200);
      setv(16'd1200, 16'd1200);
      chk(audio_mute_q, 1);
      setv(16'd500, 16'd1200);
      chk(hw_reset_q, 1);
      setv(16'd1200, 16'd1200);
      chk({hw_reset_q, restore_mem_a_q}, 2'b01);
      sec(3);
      chk(audio_mute_q, 0);
      apb(1'b1, `BPM_ADDR_CTRL, 32'h3);
      apb(1'b0, `BPM_ADDR_CTRL, 32'h0);
      chk(rd[1:0], 1);
      apb(1'b1, `BPM_ADDR_CTRL, 32'h2);
      dip();
      chk(gain_cut_db_q, 3);
      sec(10);
      dip();
      chk(gain_cut_db_q, 3);
      sec(25);
      dip();
      chk(gain_cut_db_q, 6);
      sec(35);
      dip();
      chk(gain_cut_db_q, 6);
      setv(16'd1050, 16'd1200);
      sec(70);
      chk(gain_cut_db_q, 3);
      setv(16'd1200, 16'd1200);
      sec(70);
      chk(gain_cut_db_q, 0);
      setv(16'd1200, rv(800, 940));
      sec(185);
      chk({audio_mute_q, gain_cut_db_q}, {1'b1, exp_cut(0, 18)});
      apb(1'b0, `BPM_ADDR_GAIN, 32'h0);
      chk(rd[9:0], {5'd18, exp_cut(0, 18)});
      setv(16'd1200, 16'd1000);
      sec(20);
      chk({audio_mute_q, gain_cut_db_q}, {1'b1, exp_cut(0, 18)});
      setv(16'd1200, 16'd1200);
      chk(audio_mute_q, 0);
      sec(11);
      chk(gain_cut_db_q, exp_cut(0, 17));
      sec(185);
      chk(gain_cut_db_q, 0);
      setv(16'd500, 16'd1200);
      chk(hw_reset_q, 1);
      setv(16'd1200, 16'd1200);
      chk({hw_reset_q, restore_mem_a_q}, 2'b01);
      finish_test();
   end
endmodule : testbench
`default_nettype wire
